// File: src/rrb_pkg.sv
// rrb_pkg: constants, codes and carriers of the range result register bank
// assumes an i2c slave front end that turns bus traffic into byte requests
package rrb_pkg;
	localparam logic [7:0] ADDR_LAST_CMD = 8'h11;
	localparam logic [7:0] ADDR_APP_MINOR = 8'h12;
	localparam logic [7:0] ADDR_APP_PATCH = 8'h13;
	localparam logic [7:0] ADDR_STATUS = 8'h1D;
	localparam logic [7:0] ADDR_SELECTOR = 8'h1E;
	localparam logic [7:0] ADDR_TID = 8'h1F;
	localparam logic [7:0] ADDR_RES_CNT = 8'h20;
	localparam logic [7:0] ADDR_QUALITY = 8'h21;
	localparam logic [7:0] ADDR_DIST_LO = 8'h22;
	localparam logic [7:0] ADDR_DIST_HI = 8'h23;
	localparam logic [7:0] ADDR_TS_B0 = 8'h24;
	localparam int SNAP_BYTES = 8;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_DIST = 16'h0000;
	localparam logic [7:0] STATUS_ERR_MIN = 8'h10;
	localparam logic [7:0] SEL_CALIB = 8'h0A;
	localparam logic [7:0] SEL_SERIAL = 8'h47;
	localparam logic [7:0] SEL_OBJECT = 8'h55;
	localparam logic [7:0] SEL_HIST_BASE = 8'h80;
	localparam logic [7:0] SEL_HIST_LAST = 8'h93;
	localparam logic [1:0] QS_SHORT_PREV_SHORT = 2'h0;
	localparam logic [1:0] QS_SHORT_PREV_BOTH = 2'h1;
	localparam logic [1:0] QS_LONG_INT = 2'h2;
	localparam logic [1:0] QS_COMPLETE = 2'h3;
	localparam logic [1:0] QS_NOT_INT = 2'h0;
	localparam logic [1:0] QS_GPIO_DELAY = 2'h2;
	localparam int TS_UNIT_NS = 200;
	localparam int CLK_PERIOD_PS = 5000;
	// a step time, not a minimum: rounds down
	localparam int TICK_CYCLES = (TS_UNIT_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);
	localparam logic [31:0] TS_RST = 32'h0000_0000;

	typedef enum logic [1:0] {CONT_CALIB, CONT_SERIAL, CONT_OBJECT, CONT_HIST} rrb_content_t;
	typedef enum logic [2:0] {
		CAUSE_COMPLETE, CAUSE_SHORT_PREV_SHORT, CAUSE_SHORT_PREV_BOTH,
		CAUSE_LONG, CAUSE_GPIO
	} rrb_cause_t;

	// one byte request from the i2c front end
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic txn_start;
		logic txn_end;
	} rrb_host_req_t;

	// content of the shared data area changed
	typedef struct packed {
		logic valid;
		rrb_content_t kind;
		logic [2:0] conv;
		logic [1:0] quarter;
	} rrb_content_upd_t;

	// one new unique object result
	typedef struct packed {
		logic valid;
		logic [5:0] reliability;
		rrb_cause_t cause;
		logic [15:0] distance;
	} rrb_result_t;
endpackage

// File: src/rrb_encode.sv
// rrb_encode: selector code and result quality byte encoder
// assumes converter index 0..4 and quarter 0..3 from the measurement engine
`timescale 1ns/1ps
module rrb_encode (
	input wire rrb_pkg::rrb_content_t kind,
	input wire logic [2:0] conv,
	input wire logic [1:0] quarter,
	input wire rrb_pkg::rrb_cause_t cause,
	input wire logic imm_opt,
	input wire logic [5:0] reliability,
	output logic [7:0] sel_code,
	output logic [7:0] quality
);
	import rrb_pkg::*;
	logic [1:0] stat;

	// selector code per content kind
	always_comb begin
		unique case (kind)
			CONT_CALIB: sel_code = SEL_CALIB;
			CONT_SERIAL: sel_code = SEL_SERIAL;
			CONT_OBJECT: sel_code = SEL_OBJECT;
			CONT_HIST: sel_code = SEL_HIST_BASE | {3'b000, conv, quarter};
		endcase
	end

	// capture status; reserved codes never produced with option clear
	always_comb begin
		if (imm_opt) begin
			unique case (cause)
				CAUSE_SHORT_PREV_SHORT: stat = QS_SHORT_PREV_SHORT;
				CAUSE_SHORT_PREV_BOTH: stat = QS_SHORT_PREV_BOTH;
				CAUSE_LONG: stat = QS_LONG_INT;
				CAUSE_COMPLETE, CAUSE_GPIO: stat = QS_COMPLETE;
				default: stat = QS_NOT_INT; // codes 5 to 7 never come from the engine
			endcase
		end else begin
			stat = (cause == CAUSE_GPIO) ? QS_GPIO_DELAY : QS_NOT_INT;
		end
		quality = {stat, reliability};
	end
endmodule // rrb_encode

// File: src/rrb_tick.sv
// rrb_tick: free-running timestamp in 0.2 us units
// assumes clk_sys at 200 MHz; one tick enable every TICK_CYCLES cycles
`timescale 1ns/1ps
module rrb_tick (
	input wire logic clk_sys,
	input wire logic resetn,
	output logic [31:0] ts
);
	import rrb_pkg::*;
	logic [5:0] div_r, div_nxt;
	logic [31:0] ts_r, ts_nxt;
	logic tick;

	// divider and counter; plain wrap, no saturation
	always_comb begin
		tick = (div_r == TICK_LAST);
		div_nxt = tick ? 6'h00 : div_r + 6'h01;
		ts_nxt = tick ? ts_r + 32'h0000_0001 : ts_r;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			div_r <= 6'h00;
			ts_r <= TS_RST;
		end else begin
			div_r <= div_nxt;
			ts_r <= ts_nxt;
		end
	end

	assign ts = ts_r;

	a_ts_step: assert property (@(posedge clk_sys) disable iff (!resetn)
		tick |=> ts_r == $past(ts_r) + 32'h0000_0001) else $error("timestamp missed step");
	a_ts_spacing: assert property (@(posedge clk_sys) disable iff (!resetn)
		tick |=> !tick [*8]) else $error("timestamp ticks too close");
	a_ts_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		(tick && ts_r == 32'hFFFF_FFFF) |=> ts_r == TS_RST) else $error("timestamp wrap");
endmodule // rrb_tick

// File: src/rrb_bank.sv
// rrb_bank: read-only result and status register bank
// assumes an i2c front end delivering byte reads/writes and transaction edges
`timescale 1ns/1ps
module rrb_bank (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire rrb_pkg::rrb_host_req_t host_req,
	output logic [7:0] rdata,
	output logic rdata_valid,
	input wire logic cmd_start,
	input wire logic cmd_done,
	input wire logic [7:0] cmd_code,
	input wire logic continuous,
	input wire logic app_rev_load,
	input wire logic [7:0] app_minor_rev,
	input wire logic [7:0] app_patch_rev,
	input wire logic status_load,
	input wire logic [7:0] status_code,
	output logic status_error,
	input wire rrb_pkg::rrb_content_upd_t content_upd,
	input wire rrb_pkg::rrb_result_t result,
	input wire logic immediate_interrupt_option,
	output logic hist_refresh
);
	import rrb_pkg::*;

	logic [7:0] last_cmd_r, last_cmd_nxt;
	logic [7:0] minor_r, minor_nxt;
	logic [7:0] patch_r, patch_nxt;
	logic [7:0] status_r, status_nxt;
	logic [7:0] sel_r, sel_nxt;
	logic [7:0] tid_r, tid_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [7:0] qual_r, qual_nxt;
	logic [15:0] dist_r, dist_nxt;
	logic [7:0] shd_r [SNAP_BYTES];
	logic [7:0] shd_nxt [SNAP_BYTES];
	logic [7:0] live [SNAP_BYTES];
	logic snap_act_r, snap_act_nxt;
	logic txn_rd_r, txn_rd_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic hist_adv;
	logic upd_any;
	logic [7:0] enc_sel;
	logic [7:0] enc_qual;
	logic [31:0] ts;
	logic [2:0] idx;
	logic in_snap;

	rrb_encode u_encode (
		.kind(content_upd.kind),
		.conv(content_upd.conv),
		.quarter(content_upd.quarter),
		.cause(result.cause),
		.imm_opt(immediate_interrupt_option),
		.reliability(result.reliability),
		.sel_code(enc_sel),
		.quality(enc_qual)
	);

	rrb_tick u_tick (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.ts(ts)
	);

	// command, revision and status bytes
	always_comb begin
		last_cmd_nxt = last_cmd_r;
		// continuous mode shows the running command from its start
		if ((cmd_start && continuous) || (cmd_done && !continuous)) begin
			last_cmd_nxt = cmd_code;
		end
		minor_nxt = app_rev_load ? app_minor_rev : minor_r;
		patch_nxt = app_rev_load ? app_patch_rev : patch_r;
		status_nxt = status_load ? status_code : status_r;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			last_cmd_r <= RST_BYTE;
			minor_r <= RST_BYTE;
			patch_r <= RST_BYTE;
			status_r <= RST_BYTE;
		end else begin
			last_cmd_r <= last_cmd_nxt;
			minor_r <= minor_nxt;
			patch_r <= patch_nxt;
			status_r <= status_nxt;
		end
	end

	// ok/error split is a plain compare on the stored code
	assign status_error = (status_r >= STATUS_ERR_MIN);

	// histogram auto advance after a host read transaction ends;
	// the last quarter of the last converter has nothing to advance to
	assign hist_adv = host_req.txn_end && txn_rd_r
		&& (sel_r >= SEL_HIST_BASE) && (sel_r < SEL_HIST_LAST);
	assign upd_any = content_upd.valid || result.valid || hist_adv;
	assign hist_refresh = hist_adv;

	// map content: selector, transaction id, object result
	always_comb begin
		sel_nxt = sel_r;
		tid_nxt = tid_r;
		cnt_nxt = cnt_r;
		qual_nxt = qual_r;
		dist_nxt = dist_r;
		// engine update wins over the auto advance in the same cycle
		if (content_upd.valid) begin
			sel_nxt = enc_sel;
		end else if (hist_adv) begin
			sel_nxt = sel_r + 8'h01;
		end
		if (result.valid) begin
			cnt_nxt = cnt_r + 8'h01;
			qual_nxt = enc_qual;
			dist_nxt = result.distance;
		end
		if (upd_any) begin
			tid_nxt = tid_r + 8'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sel_r <= RST_BYTE;
			tid_r <= RST_BYTE;
			cnt_r <= RST_BYTE;
			qual_r <= RST_BYTE;
			dist_r <= RST_DIST;
		end else begin
			sel_r <= sel_nxt;
			tid_r <= tid_nxt;
			cnt_r <= cnt_nxt;
			qual_r <= qual_nxt;
			dist_r <= dist_nxt;
		end
	end

	// live view of the block that the host fetches in one transfer
	always_comb begin
		live[0] = status_r;
		live[1] = sel_r;
		live[2] = tid_r;
		live[3] = cnt_r;
		live[4] = qual_r;
		live[5] = dist_r[7:0];
		live[6] = dist_r[15:8];
		live[7] = ts[7:0];
	end

	// snapshot at transaction start so a block read sees one coherent set;
	// the engine keeps updating live registers meanwhile
	always_comb begin
		snap_act_nxt = snap_act_r;
		txn_rd_nxt = txn_rd_r;
		for (int i = 0; i < SNAP_BYTES; i++) begin
			shd_nxt[i] = host_req.txn_start ? live[i] : shd_r[i];
		end
		if (host_req.txn_start) begin
			snap_act_nxt = 1'b1;
			txn_rd_nxt = host_req.rd; // a read in the start cycle belongs to the new transfer
		end else if (host_req.txn_end) begin
			snap_act_nxt = 1'b0;
			txn_rd_nxt = 1'b0;
		end else if (host_req.rd) begin
			txn_rd_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			snap_act_r <= 1'b0;
			txn_rd_r <= 1'b0;
			for (int i = 0; i < SNAP_BYTES; i++) begin
				shd_r[i] <= RST_BYTE;
			end
		end else begin
			snap_act_r <= snap_act_nxt;
			txn_rd_r <= txn_rd_nxt;
			for (int i = 0; i < SNAP_BYTES; i++) begin
				shd_r[i] <= shd_nxt[i];
			end
		end
	end

	// read decode; unmapped bytes read zero, writes are dropped
	assign in_snap = (host_req.addr >= ADDR_STATUS) && (host_req.addr <= ADDR_TS_B0);
	assign idx = 3'(host_req.addr - ADDR_STATUS);

	always_comb begin
		rdata_nxt = rdata_r;
		rvalid_nxt = host_req.rd;
		if (host_req.rd) begin
			if (in_snap) begin
				rdata_nxt = snap_act_r ? shd_r[idx] : live[idx];
			end else begin
				unique case (host_req.addr)
					ADDR_LAST_CMD: rdata_nxt = last_cmd_r;
					ADDR_APP_MINOR: rdata_nxt = minor_r;
					ADDR_APP_PATCH: rdata_nxt = patch_r;
					default: rdata_nxt = RST_BYTE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rdata_r <= RST_BYTE;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign rdata = rdata_r;
	assign rdata_valid = rvalid_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_cmd_latch: assert property ((cmd_done && !continuous) |=>
		last_cmd_r == $past(cmd_code)) else $error("last command not latched");
	a_cmd_cont: assert property ((cmd_start && continuous) |=>
		last_cmd_r == $past(cmd_code)) else $error("running command not shown");
	a_status_flag: assert property (status_load |=>
		status_error == ($past(status_code) >= STATUS_ERR_MIN)) else $error("status class");
	a_sel_object: assert property ((content_upd.valid && content_upd.kind == CONT_OBJECT)
		|=> sel_r == SEL_OBJECT) else $error("object selector");
	a_sel_hist: assert property ((content_upd.valid && content_upd.kind == CONT_HIST)
		|=> sel_r == SEL_HIST_BASE + {3'b000, $past(content_upd.conv),
		$past(content_upd.quarter)}) else $error("histogram selector");
	a_tid_change: assert property (upd_any |=> tid_r != $past(tid_r))
		else $error("tid unchanged on update");
	a_cnt_incr: assert property (result.valid |=> cnt_r == $past(cnt_r) + 8'h01)
		else $error("result counter step");
	a_qual_rel: assert property (result.valid |=>
		qual_r[5:0] == $past(result.reliability)) else $error("reliability field");
	a_qual_opt: assert property ((result.valid && immediate_interrupt_option
		&& result.cause == CAUSE_LONG) |=> qual_r[7:6] == QS_LONG_INT) else $error("long int code");
	a_qual_gpio: assert property ((result.valid && !immediate_interrupt_option) |=>
		qual_r[7:6] == (($past(result.cause) == CAUSE_GPIO) ? QS_GPIO_DELAY : QS_NOT_INT))
		else $error("gpio delay code");
	a_dist_read: assert property ((host_req.rd && host_req.addr == ADDR_DIST_HI
		&& !snap_act_r) |=> rdata_valid && rdata == $past(dist_r[15:8])) else $error("dist hi");
	a_hist_auto: assert property ((hist_adv && !content_upd.valid) |=>
		sel_r == $past(sel_r) + 8'h01 && tid_r != $past(tid_r)) else $error("histogram advance");
	a_ro_write: assert property ((host_req.wr && !upd_any && !status_load) |=>
		$stable(sel_r) && $stable(status_r) && $stable(cnt_r)) else $error("write changed bank");

	// remaining selector and capture status codes
	a_sel_calib: assert property (content_upd.valid
		&& content_upd.kind == CONT_CALIB |=> sel_r == SEL_CALIB)
		else $error("calibration selector");
	a_sel_serial: assert property (content_upd.valid
		&& content_upd.kind == CONT_SERIAL |=> sel_r == SEL_SERIAL)
		else $error("serial selector");
	a_qual_short: assert property (result.valid && immediate_interrupt_option
		&& result.cause == CAUSE_SHORT_PREV_SHORT |=> qual_r[7:6] == QS_SHORT_PREV_SHORT)
		else $error("short interrupt code");
	a_qual_both: assert property (result.valid && immediate_interrupt_option
		&& result.cause == CAUSE_SHORT_PREV_BOTH |=> qual_r[7:6] == QS_SHORT_PREV_BOTH)
		else $error("short and long interrupt code");
	a_qual_full: assert property (result.valid && immediate_interrupt_option
		&& (result.cause == CAUSE_COMPLETE || result.cause == CAUSE_GPIO)
		|=> qual_r[7:6] == QS_COMPLETE) else $error("complete code");
	// the last quarter of the last converter must not advance
	a_hist_stop: assert property (host_req.txn_end && sel_r == SEL_HIST_LAST
		|-> !hist_refresh) else $error("advance past last quarter");
	// registers move only on their own events
	a_cmd_hold: assert property (!(cmd_start && continuous)
		&& !(cmd_done && !continuous) |=> $stable(last_cmd_r)) else $error("command changed");
	a_status_hold: assert property (!status_load |=> $stable(status_r))
		else $error("status changed");
	a_res_hold: assert property (!result.valid |=> $stable(cnt_r) && $stable(dist_r))
		else $error("result changed");
	a_tid_hold: assert property (!upd_any |=> $stable(tid_r))
		else $error("tid changed without update");
	// read paths of the block fetched in one transfer
	a_dist_lo: assert property (host_req.rd && host_req.addr == ADDR_DIST_LO
		&& !snap_act_r |=> rdata == $past(dist_r[7:0])) else $error("dist lo");
	a_ts_read: assert property (host_req.rd && host_req.addr == ADDR_TS_B0
		&& !snap_act_r |=> rdata == $past(ts[7:0])) else $error("timestamp byte");
	a_snap_read: assert property (host_req.rd && in_snap && snap_act_r
		|=> rdata == $past(shd_r[idx])) else $error("shadow read");
	a_wr_silent: assert property (host_req.wr && !host_req.rd |=> !rdata_valid)
		else $error("write answered");

	// scenarios worth seeing
	c_hist_walk: cover property (hist_adv ##[1:200] hist_adv);
	c_object: cover property (content_upd.valid && content_upd.kind == CONT_OBJECT
		##1 result.valid);
	c_snap_read: cover property (host_req.txn_start ##1 (host_req.rd && result.valid));
	c_write_drop: cover property (host_req.wr && host_req.addr == ADDR_TID);
	c_cont_cmd: cover property (cmd_start && continuous);
endmodule // rrb_bank

// File: testbench/rrb_host_model.sv
// rrb_host_model: i2c front end stand-in that issues byte requests to the bank
// assumes clk_sys from the bench; requests change just after rising edges
`timescale 1ns/1ps
module rrb_host_model (
	output rrb_pkg::rrb_host_req_t host_req,
	input wire logic clk_sys
);
	import rrb_pkg::*;
	// quiet bus at time zero
	initial begin
		host_req = '0;
	end
	// one byte access, one-cycle pulse; released address and data show inverted values, never stale ones
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		host_req.rd <= ~wr;
		host_req.wr <= wr;
		host_req.addr <= a;
		host_req.wdata <= d;
		@(posedge clk_sys);
		host_req.rd <= 1'b0;
		host_req.wr <= 1'b0;
		host_req.addr <= ~a;
		host_req.wdata <= ~d;
	endtask
	// start or stop edge; the extra wait keeps stop a cycle clear of the last read
	task automatic frame(input logic stop);
		@(posedge clk_sys);
		host_req.txn_start <= ~stop;
		host_req.txn_end <= stop;
		@(posedge clk_sys);
		host_req.txn_start <= 1'b0;
		host_req.txn_end <= 1'b0;
	endtask
endmodule // rrb_host_model

// File: testbench/testbench.sv
// testbench: self-checking bench of the range result register bank
// assumes rrb_host_model in place of the i2c front end; engine inputs driven here
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
	import rrb_pkg::*;
	logic clk_sys, resetn, rdata_valid, status_error, hist_refresh;
	logic cmd_start, cmd_done, continuous, app_rev_load, status_load, immediate_interrupt_option;
	logic [7:0] rdata, cmd_code, app_minor_rev, app_patch_rev, status_code;
	rrb_host_req_t host_req;
	rrb_content_upd_t content_upd;
	rrb_result_t result;
	int checks = 0;
	int fails = 0;
	int refreshes = 0;
	integer seed = 32'h8674;
	logic [31:0] v;
	logic [7:0] tid_e, cnt_e, ql_e, ts_a;
	logic [15:0] d_e;
	logic [8:0] exp_q[$];
	logic [8:0] blk [11];
	logic [7:0] addrs [14] = '{8'h11, 8'h12, 8'h13, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21,
		8'h22, 8'h23, 8'h25, 8'h26, 8'h27, 8'h50};
	logic [7:0] scodes [4] = '{8'h0F, 8'h10, 8'hFF, 8'h00};

	rrb_host_model i_host (.host_req(host_req), .clk_sys(clk_sys));
	rrb_bank i_dut (.clk_sys(clk_sys), .resetn(resetn), .host_req(host_req), .rdata(rdata),
		.rdata_valid(rdata_valid), .cmd_start(cmd_start), .cmd_done(cmd_done),
		.cmd_code(cmd_code), .continuous(continuous), .app_rev_load(app_rev_load),
		.app_minor_rev(app_minor_rev), .app_patch_rev(app_patch_rev),
		.status_load(status_load), .status_code(status_code), .status_error(status_error),
		.content_upd(content_upd), .result(result),
		.immediate_interrupt_option(immediate_interrupt_option), .hist_refresh(hist_refresh));

	// 200 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// hang guard, far beyond the roughly nine hundred cycles the tests take
	initial begin
		#100_000;
		fails++;
		report_and_stop();
	end
	// read answers are taken mid-cycle so the launching edge has settled
	always @(negedge clk_sys) begin
		if (hist_refresh !== 1'b0) refreshes++;
		if (rdata_valid !== 1'b0) begin
			// an answer with no read noted counts as a mismatch
			`CHK(exp_q.size() != 0, 1'b1)
			if (exp_q.size() != 0) begin
				if (exp_q[0][8] == 1'b0) `CHK(rdata, exp_q[0][7:0])
				void'(exp_q.pop_front());
			end
		end
	end

	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// note the expectation, then let the host read
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({1'b0, e});
		i_host.access(1'b0, a, 8'h00);
	endtask
	task automatic cmd(input logic cont, input logic st, input logic [7:0] c, input logic [7:0] e);
		@(posedge clk_sys);
		continuous <= cont;
		cmd_code <= c;
		cmd_start <= st;
		cmd_done <= ~st;
		@(posedge clk_sys);
		cmd_start <= 1'b0;
		cmd_done <= 1'b0;
		rd(ADDR_LAST_CMD, e);
	endtask
	task automatic content(input rrb_content_t k, input logic [2:0] c, input logic [1:0] q,
		input logic [7:0] e);
		@(posedge clk_sys);
		content_upd <= '{1'b1, k, c, q};
		@(posedge clk_sys);
		content_upd.valid <= 1'b0;
		tid_e++;
		rd(ADDR_SELECTOR, e);
		rd(ADDR_TID, tid_e);
	endtask
	// expected capture status field from option and cause
	function automatic logic [1:0] qs(input logic o, input rrb_cause_t c);
		if (!o) return (c == CAUSE_GPIO) ? QS_GPIO_DELAY : QS_NOT_INT;
		case (c)
			CAUSE_SHORT_PREV_SHORT: return QS_SHORT_PREV_SHORT;
			CAUSE_SHORT_PREV_BOTH: return QS_SHORT_PREV_BOTH;
			CAUSE_LONG: return QS_LONG_INT;
			default: return QS_COMPLETE;
		endcase
	endfunction

	// main sequence
	initial begin
		{resetn, cmd_start, cmd_done, continuous, app_rev_load, status_load} = '0;
		{cmd_code, app_minor_rev, app_patch_rev, status_code, immediate_interrupt_option} = '0;
		content_upd = '0;
		result = '0;
		tid_e = 8'h00;
		cnt_e = 8'h00;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			foreach (addrs[i]) rd(addrs[i], 8'h00);
			foreach (addrs[i]) i_host.access(1'b1, addrs[i], 8'hFF);
		end
		$display("test reset and writes done");
		cmd(1'b0, 1'b1, 8'h11, 8'h00);
		cmd(1'b0, 1'b0, 8'h11, 8'h11);
		cmd(1'b1, 1'b0, 8'h22, 8'h11);
		cmd(1'b1, 1'b1, 8'h04, 8'h04);
		cmd(1'b0, 1'b1, 8'h33, 8'h04);
		v = $random(seed);
		@(posedge clk_sys);
		app_rev_load <= 1'b1;
		app_minor_rev <= v[7:0];
		app_patch_rev <= v[15:8];
		@(posedge clk_sys);
		app_rev_load <= 1'b0;
		rd(ADDR_APP_MINOR, v[7:0]);
		rd(ADDR_APP_PATCH, v[15:8]);
		foreach (scodes[i]) begin
			@(posedge clk_sys);
			status_load <= 1'b1;
			status_code <= scodes[i];
			@(posedge clk_sys);
			status_load <= 1'b0;
			rd(ADDR_STATUS, scodes[i]);
			`CHK(status_error, scodes[i] >= STATUS_ERR_MIN)
		end
		$display("test command, revision and status done");
		content(CONT_CALIB, 3'd0, 2'd0, SEL_CALIB);
		content(CONT_SERIAL, 3'd0, 2'd0, SEL_SERIAL);
		content(CONT_OBJECT, 3'd0, 2'd0, SEL_OBJECT);
		for (int c = 0; c < 5; c++)
			for (int q = 0; q < 4; q++)
				content(CONT_HIST, 3'(c), 2'(q), SEL_HIST_BASE + 8'(4 * c + q));
		$display("test content selector done");
		for (int o = 0; o < 2; o++) begin
			for (int c = 0; c < 5; c++) begin
				v = $random(seed);
				@(posedge clk_sys);
				immediate_interrupt_option <= o[0];
				result <= '{1'b1, v[5:0], rrb_cause_t'(c), v[31:16]};
				@(posedge clk_sys);
				result.valid <= 1'b0;
				cnt_e++;
				tid_e++;
				ql_e = {qs(o[0], rrb_cause_t'(c)), v[5:0]};
				d_e = v[31:16];
				rd(ADDR_RES_CNT, cnt_e);
				rd(ADDR_QUALITY, ql_e);
				rd(ADDR_DIST_LO, d_e[7:0]);
				rd(ADDR_DIST_HI, d_e[15:8]);
				rd(ADDR_TID, tid_e);
			end
		end
		$display("test results done");
		// block read: a result landing mid-read must not show until the stop
		i_host.frame(1'b0);
		@(posedge clk_sys);
		result <= '{1'b1, 6'h3F, CAUSE_COMPLETE, 16'hBEEF};
		@(posedge clk_sys);
		result.valid <= 1'b0;
		blk = '{9'h000, {1'b0, SEL_HIST_LAST}, {1'b0, tid_e}, {1'b0, cnt_e}, {1'b0, ql_e},
			{1'b0, d_e[7:0]}, {1'b0, d_e[15:8]}, 9'h100, 9'h000, 9'h000, 9'h000};
		foreach (blk[i]) begin
			exp_q.push_back(blk[i]);
			i_host.access(1'b0, 8'h1D + 8'(i), 8'h00);
		end
		i_host.frame(1'b1);
		cnt_e++;
		tid_e++;
		rd(ADDR_RES_CNT, cnt_e);
		rd(ADDR_QUALITY, 8'hFF);
		rd(ADDR_SELECTOR, SEL_HIST_LAST);
		rd(ADDR_TID, tid_e);
		`CHK(refreshes, 0)
		content(CONT_HIST, 3'd4, 2'd2, 8'h92);
		i_host.frame(1'b0);
		rd(ADDR_SELECTOR, 8'h92);
		i_host.frame(1'b1);
		tid_e++;
		`CHK(refreshes, 1)
		rd(ADDR_SELECTOR, SEL_HIST_LAST);
		rd(ADDR_TID, tid_e);
		$display("test block read and histogram advance done");
		// timestamp: two reads launched exactly 400 cycles apart
		exp_q.push_back(9'h100);
		i_host.access(1'b0, ADDR_TS_B0, 8'h00);
		@(negedge clk_sys);
		ts_a = rdata;
		repeat (398) @(posedge clk_sys);
		rd(ADDR_TS_B0, ts_a + 8'(400 / TICK_CYCLES));
		repeat (3) @(posedge clk_sys);
		`CHK(exp_q.size(), 0)
		$display("test timestamp done");
		report_and_stop();
	end
endmodule // testbench
